// >>> adcsd_decoder.sv
// serial command decoder of the converter: sclk side shifts and decodes,
// sys_clk side runs standby, reset, conversion and data-ready control
// assumes sclk runs only while cs_n is low; conversion results arrive on sys_clk
`timescale 1ns/10ps
`default_nettype none

module adcsd_decoder (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire logic start_pin,
    input wire logic conv_valid,
    input wire logic [adcsd_pkg::DATA_W-1:0] conv_data,
    output logic data_ready_n,
    output logic conv_enable,
    output logic standby,
    output logic filter_reset,
    output logic offset_calibrate_cmd,
    output logic calibration_enable_bit,
    output logic read_continuous
);
    import adcsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // sclk side declarations

    logic frame_rst;
    logic [2:0] bit_cnt_r;
    logic [7:0] sh_r;
    adcsd_phase_t phase_r;
    adcsd_phase_t phase_nxt;
    logic [4:0] addr_r;
    logic [4:0] addr_nxt;
    logic [4:0] left_r;
    logic [4:0] left_nxt;
    logic is_rd_r;
    logic is_rd_nxt;
    logic started_r;
    logic rdata_pend_r;
    logic rdata_pend_nxt;
    logic [DATA_W-1:0] out_sh_r;
    logic [DATA_W-1:0] out_sh_nxt;
    logic [6:0] out_left_r;
    logic [6:0] out_left_nxt;
    logic wr_en;
    logic cont_mode_r;
    adcsd_cmd_t cmd_r;
    adcsd_cmd_t cmd_code;
    logic cmd_tog_r;
    logic [7:0] regs_r [0:REG_NUM-1];
    logic dout_r;
    logic dout_oe_r;

    // sys side word held for the sclk side
    logic [DATA_W-1:0] out_word_r;

    ////////////////////////////////////////////////////////////////////////
    // sclk side decode

    // cs_n high ends a frame and clears the per-frame state
    assign frame_rst = rst | cs_n;

    wire [7:0] byte_in = {sh_r[6:0], din};
    wire [6:0] top7 = byte_in[6:0];
    wire bit7 = (bit_cnt_r == 3'h6);
    wire bit8 = (bit_cnt_r == 3'h7);
    wire op_phase = (phase_r == PH_OP);
    wire dec7 = op_phase & bit7;
    wire dec8 = op_phase & bit8;
    wire is_register_read_cmd = (byte_in[7:5] == PFX_REGISTER_READ_CMD);
    wire is_register_write_cmd = (byte_in[7:5] == PFX_REGISTER_WRITE_CMD);
    wire [4:0] rd_addr = (phase_r == PH_REGISTER_READ_CMD) ? addr_r + 5'h01 : addr_r;
    wire [7:0] rd_val = (rd_addr <= REG_LAST) ? regs_r[rd_addr[3:0]] : 8'h00;
    wire wr_ok = wr_en & (addr_r != REG_ID) & (addr_r <= REG_LAST);
    wire out_busy = (out_left_r != 7'h00);

    always_comb begin
        cmd_code = CMD_NONE;
        if (dec7) begin
            unique case (top7)
                OP_WAKE[7:1]: cmd_code = CMD_WAKE;
                OP_STANDBY[7:1]: cmd_code = CMD_STANDBY;
                OP_RESET[7:1]: cmd_code = CMD_RESET;
                OP_START[7:1]: cmd_code = CMD_START;
                OP_STOP[7:1]: cmd_code = CMD_STOP;
                OP_OFFCAL[7:1]: cmd_code = CMD_OFFCAL;
                default: cmd_code = CMD_NONE;
            endcase
        end else if (dec8) begin
            if (byte_in == OP_READ_CONTINUOUS_CMD) begin
                cmd_code = CMD_READ_CONTINUOUS_CMD;
            end else if (byte_in == OP_STOP_CONTINUOUS_CMD) begin
                cmd_code = CMD_STOP_CONTINUOUS_CMD;
            end
        end
    end

    always_comb begin
        phase_nxt = phase_r;
        addr_nxt = addr_r;
        left_nxt = left_r;
        is_rd_nxt = is_rd_r;
        rdata_pend_nxt = rdata_pend_r;
        wr_en = 1'b0;
        out_sh_nxt = out_busy ? {out_sh_r[DATA_W-2:0], 1'b0} : out_sh_r;
        out_left_nxt = out_busy ? out_left_r - 7'h01 : out_left_r;
        // continuous readout: the held result streams from the first edge
        if (!started_r && cont_mode_r) begin
            out_sh_nxt = {out_word_r[DATA_W-2:0], 1'b0};
            out_left_nxt = DATA_BITS - 7'h01;
        end
        if (dec7 && top7 == OP_RDATA[7:1]) begin
            rdata_pend_nxt = 1'b1;
        end
        if (bit8) begin
            unique case (phase_r)
                PH_OP: begin
                    if (rdata_pend_r) begin
                        out_sh_nxt = out_word_r;
                        out_left_nxt = DATA_BITS;
                        rdata_pend_nxt = 1'b0;
                    end
                    if (is_register_read_cmd && cont_mode_r) begin
                        phase_nxt = PH_SKIP;
                    end else if (is_register_read_cmd || is_register_write_cmd) begin
                        phase_nxt = PH_CNT;
                        addr_nxt = byte_in[4:0];
                        is_rd_nxt = is_register_read_cmd;
                    end
                end
                PH_SKIP: begin
                    phase_nxt = PH_OP;
                end
                PH_CNT: begin
                    left_nxt = byte_in[4:0];
                    phase_nxt = is_rd_r ? PH_REGISTER_READ_CMD : PH_REGISTER_WRITE_CMD;
                    if (is_rd_r) begin
                        out_sh_nxt = {rd_val, 64'h0000_0000_0000_0000};
                        out_left_nxt = BYTE_BITS;
                    end
                end
                PH_REGISTER_READ_CMD: begin
                    if (left_r == 5'h00) begin
                        phase_nxt = PH_OP;
                    end else begin
                        left_nxt = left_r - 5'h01;
                        addr_nxt = rd_addr;
                        out_sh_nxt = {rd_val, 64'h0000_0000_0000_0000};
                        out_left_nxt = BYTE_BITS;
                    end
                end
                PH_REGISTER_WRITE_CMD: begin
                    wr_en = 1'b1;
                    if (left_r == 5'h00) begin
                        phase_nxt = PH_OP;
                    end else begin
                        left_nxt = left_r - 5'h01;
                        addr_nxt = addr_r + 5'h01;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sclk side registers: input sampled on falling edges

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_r <= 3'h0;
            sh_r <= 8'h00;
            phase_r <= PH_OP;
            addr_r <= 5'h00;
            left_r <= 5'h00;
            is_rd_r <= 1'b0;
            started_r <= 1'b0;
            rdata_pend_r <= 1'b0;
            out_sh_r <= '0;
            out_left_r <= 7'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sh_r <= byte_in;
            phase_r <= phase_nxt;
            addr_r <= addr_nxt;
            left_r <= left_nxt;
            is_rd_r <= is_rd_nxt;
            started_r <= 1'b1;
            rdata_pend_r <= rdata_pend_nxt;
            out_sh_r <= out_sh_nxt;
            out_left_r <= out_left_nxt;
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            cont_mode_r <= 1'b1;
            cmd_r <= CMD_NONE;
            cmd_tog_r <= 1'b0;
        end else begin
            if (cmd_code == CMD_READ_CONTINUOUS_CMD) begin
                cont_mode_r <= 1'b1;
            end else if (cmd_code == CMD_STOP_CONTINUOUS_CMD) begin
                cont_mode_r <= 1'b0;
            end
            if (cmd_code != CMD_NONE) begin
                cmd_r <= cmd_code;
                cmd_tog_r <= ~cmd_tog_r;
            end
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_r[i] <= REG_RST_VEC[i*8 +: 8];
            end
        end else if (cmd_code == CMD_RESET) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_r[i] <= REG_RST_VEC[i*8 +: 8];
            end
        end else if (wr_ok) begin
            regs_r[addr_r[3:0]] <= byte_in;
        end
    end

    // output changes on rising edges, sampled by the host on falling edges
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end else begin
            dout_r <= started_r ? (out_busy & out_sh_r[DATA_W-1])
                                : (cont_mode_r & out_word_r[DATA_W-1]);
            dout_oe_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossings into the master clock domain

    logic cs_q;
    logic tog_q;
    logic start_q;

    adcsd_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk(sys_clk),
        .rst(rst),
        .d(cs_n),
        .q(cs_q)
    );

    adcsd_sync #(.W(1), .RST_VAL(1'b0)) u_tog_sync (
        .clk(sys_clk),
        .rst(rst),
        .d(cmd_tog_r),
        .q(tog_q)
    );

    adcsd_sync #(.W(1), .RST_VAL(1'b0)) u_start_sync (
        .clk(sys_clk),
        .rst(rst),
        .d(start_pin),
        .q(start_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // master clock side control

    logic tog_seen_r;
    logic cs_d_r;
    logic standby_r;
    logic standby_nxt;
    logic run_cmd_r;
    logic run_cmd_nxt;
    logic stop_pend_r;
    logic stop_pend_nxt;
    logic [5:0] rst_cnt_r;
    logic [5:0] rst_cnt_nxt;
    logic conv_enable_r;
    logic filter_reset_r;
    logic offcal_r;
    logic data_ready_n_n_r;
    logic data_ready_n_n_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [DATA_W-1:0] pend_word_r;
    logic [DATA_W-1:0] out_word_nxt;

    // cmd_r is stable by the time its toggle has crossed
    wire cmd_evt = (tog_q != tog_seen_r);
    wire cmd_ok = cmd_evt & (~standby_r | cmd_r == CMD_WAKE) & (rst_cnt_r == 6'h00);
    wire do_wake = cmd_ok & (cmd_r == CMD_WAKE);
    wire do_standby = cmd_ok & (cmd_r == CMD_STANDBY);
    wire do_reset = cmd_ok & (cmd_r == CMD_RESET);
    wire do_start = cmd_ok & (cmd_r == CMD_START);
    wire do_stop = cmd_ok & (cmd_r == CMD_STOP);
    wire do_offcal = cmd_ok & (cmd_r == CMD_OFFCAL);
    wire conv_take = conv_valid & conv_enable_r;
    wire cs_fall = cs_d_r & ~cs_q;

    always_comb begin
        standby_nxt = standby_r;
        if (do_standby) begin
            standby_nxt = 1'b1;
        end else if (do_wake) begin
            standby_nxt = 1'b0;
        end
        run_cmd_nxt = run_cmd_r;
        stop_pend_nxt = stop_pend_r;
        if (do_start && !run_cmd_r) begin
            run_cmd_nxt = 1'b1;
        end
        if (do_stop && run_cmd_r) begin
            stop_pend_nxt = 1'b1;
        end
        if (conv_take && stop_pend_r) begin
            run_cmd_nxt = 1'b0;
            stop_pend_nxt = 1'b0;
        end
        rst_cnt_nxt = (rst_cnt_r != 6'h00) ? rst_cnt_r - 6'h01 : 6'h00;
        if (do_reset) begin
            rst_cnt_nxt = RESET_CYC;
        end
    end

    // a result is never swapped under a running frame; it waits for cs_n high
    always_comb begin
        out_word_nxt = out_word_r;
        pend_nxt = pend_r;
        data_ready_n_n_nxt = data_ready_n_n_r;
        if (cs_fall) begin
            data_ready_n_n_nxt = 1'b1;
        end
        if (conv_take && !cs_q) begin
            pend_nxt = 1'b1;
        end else if (conv_take) begin
            out_word_nxt = conv_data;
            data_ready_n_n_nxt = 1'b0;
            pend_nxt = 1'b0;
        end else if (pend_r && cs_q) begin
            out_word_nxt = pend_word_r;
            data_ready_n_n_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tog_seen_r <= 1'b0;
            cs_d_r <= 1'b1;
            standby_r <= 1'b0;
            run_cmd_r <= 1'b0;
            stop_pend_r <= 1'b0;
            rst_cnt_r <= 6'h00;
        end else begin
            tog_seen_r <= tog_q;
            cs_d_r <= cs_q;
            standby_r <= standby_nxt;
            run_cmd_r <= run_cmd_nxt;
            stop_pend_r <= stop_pend_nxt;
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_enable_r <= 1'b0;
            filter_reset_r <= 1'b0;
            offcal_r <= 1'b0;
        end else begin
            conv_enable_r <= (run_cmd_nxt | start_q) & ~standby_nxt & (rst_cnt_nxt == 6'h00);
            filter_reset_r <= (rst_cnt_nxt != 6'h00);
            offcal_r <= do_offcal;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_word_r <= '0;
            pend_word_r <= '0;
            pend_r <= 1'b0;
            data_ready_n_n_r <= 1'b1;
        end else begin
            out_word_r <= out_word_nxt;
            if (conv_take && !cs_q) begin
                pend_word_r <= conv_data;
            end
            pend_r <= pend_nxt;
            data_ready_n_n_r <= data_ready_n_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign dout = dout_r;
    assign dout_oe = dout_oe_r;
    assign data_ready_n = data_ready_n_n_r;
    assign conv_enable = conv_enable_r;
    assign standby = standby_r;
    assign filter_reset = filter_reset_r;
    assign offset_calibrate_cmd = offcal_r;
    assign calibration_enable_bit = regs_r[REG_RESP2[3:0]][CALIB_BIT];
    assign read_continuous = cont_mode_r;

endmodule
`default_nettype wire

// >>> adcsd_pkg.sv
// constants, encodings and state types of the serial command decoder
// assumes sys_clk is the converter master clock and sclk comes from the host
//
// How it works
// - opcodes are one byte; register read and write add a count byte and data
// - system commands and on-demand read decode on the seventh falling sclk edge
// - register read and write opcodes decode on the eighth falling sclk edge
// - wake 02, standby 04, reset 06, start 08, stop 0A, offset calibration 1A
// - continuous readout 10, stop continuous 11, on-demand read 12
// - read is 001+address, write 010+address; second byte 000+count minus one
// - register read is ignored while continuous readout is on
// - standby shuts everything but the reference until wake
// - reset command restarts the filter and restores register defaults
// - start begins conversions; no effect when already running
// - stop lets the running conversion finish; no effect when stopped
// - continuous readout loads each result at data ready; power-up default
// - on-demand read needs no wait and may overlap next data ready safely
// - register read drives first register msb on the 17th rising sclk edge
// - register write data bytes follow the opcode bytes, msb first

package adcsd_pkg;

    localparam logic [7:0] OP_WAKE = 8'h02;
    localparam logic [7:0] OP_STANDBY = 8'h04;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_START = 8'h08;
    localparam logic [7:0] OP_STOP = 8'h0A;
    localparam logic [7:0] OP_OFFCAL = 8'h1A;
    localparam logic [7:0] OP_READ_CONTINUOUS_CMD = 8'h10;
    localparam logic [7:0] OP_STOP_CONTINUOUS_CMD = 8'h11;
    localparam logic [7:0] OP_RDATA = 8'h12;
    localparam logic [2:0] PFX_REGISTER_READ_CMD = 3'h1;
    localparam logic [2:0] PFX_REGISTER_WRITE_CMD = 3'h2;

    localparam int unsigned REG_NUM = 12;
    localparam logic [4:0] REG_ID = 5'h00;
    localparam logic [4:0] REG_LAST = 5'h0B;
    localparam logic [4:0] REG_RESP2 = 5'h0A;
    localparam int unsigned CALIB_BIT = 7;
    // identity value is arbitrary
    localparam logic [7:0] ID_VALUE = 8'h5A;
    // register defaults, register 0 in the low byte
    localparam logic [95:0] REG_RST_VEC = {8'h0C, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00, 8'h10, 8'h80, 8'h02, ID_VALUE};

    localparam int unsigned DATA_W = 72;
    localparam logic [6:0] DATA_BITS = 7'h48;
    localparam logic [6:0] BYTE_BITS = 7'h08;

    // waits in master clock periods; sys_clk is the master clock (50 ns)
    localparam int unsigned MCLK_NS = 50;
    localparam int unsigned CMD_GAP_TCLK = 4;
    localparam int unsigned MOD_TCLK = 4;
    localparam int unsigned RESET_TMOD = 9;
    localparam logic [5:0] RESET_CYC = 6'(RESET_TMOD * MOD_TCLK);

    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_WAKE = 4'b0001,
        CMD_STANDBY = 4'b0010,
        CMD_RESET = 4'b0011,
        CMD_START = 4'b0100,
        CMD_STOP = 4'b0101,
        CMD_OFFCAL = 4'b0110,
        CMD_READ_CONTINUOUS_CMD = 4'b0111,
        CMD_STOP_CONTINUOUS_CMD = 4'b1000
    } adcsd_cmd_t;

    typedef enum logic [2:0] {
        PH_OP = 3'b000,
        PH_CNT = 3'b001,
        PH_REGISTER_WRITE_CMD = 3'b010,
        PH_REGISTER_READ_CMD = 3'b011,
        PH_SKIP = 3'b100
    } adcsd_phase_t;

endpackage

// >>> adcsd_sync.sv
// three-stage synchroniser with agreement filter
// assumes d is a level from another clock domain or a pin
`timescale 1ns/10ps
`default_nettype none

module adcsd_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // a change counts once the second and third stage agree
    assign q_nxt = (s2_r == s3_r) ? s3_r : q_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule
`default_nettype wire

// >>> adcsd_host.sv
// host side serial controller model for the command decoder
// assumes the bench calls its tasks; sclk stands low outside frames
`timescale 1ns/10ps
`default_nettype none
module adcsd_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic din,
    input wire logic dout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // cs_n low for the whole command
    task automatic open_f();
        cs_n = 1'b0;
        #250;
    endtask
    // released data line shows the inverse, not the last bit
    task automatic close_f();
        cs_n = 1'b1;
        din = ~din;
        #250;
    endtask
    // one byte msb first, then 5 master clocks of gap
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            din = tx[i];
            #31.25 sclk = 1'b1;
            #62.5 rx[i] = dout;
            sclk = 1'b0;
            // din moves mid low phase, clear of the falling sample edge
            #31.25;
        end
        #250;
    endtask
endmodule
`default_nettype wire

// >>> adcsd_decoder_sva.sv
// port assertions of the command decoder, sys_clk domain
// assumes cs_n stays high while conv_valid pulses
`timescale 1ns/10ps
`default_nettype none
module adcsd_decoder_sva (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic conv_valid,
    input wire logic data_ready_n,
    input wire logic conv_enable,
    input wire logic standby,
    input wire logic filter_reset,
    input wire logic offset_calibrate_cmd
);
    logic [5:0] frst_cnt_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frst_cnt_r <= 6'h00;
        end else begin
            frst_cnt_r <= filter_reset ? frst_cnt_r + 6'h01 : 6'h00;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    result_flag_a: assert property (cs_n[*6] ##0 (conv_valid && conv_enable) |=> !data_ready_n)
        else $error("result not flagged");
    flag_hold_a: assert property (cs_n[*7] ##0 (!data_ready_n && !filter_reset) |=> !data_ready_n)
        else $error("flag dropped");
    halted_conv_a: assert property (cs_n[*7] ##0 (conv_valid && !conv_enable && data_ready_n) |=> data_ready_n)
        else $error("halted result flagged");
    cal_pulse_a: assert property (offset_calibrate_cmd |=> !offset_calibrate_cmd)
        else $error("calibration pulse too long");
    standby_off_a: assert property (standby && $past(standby) |-> !conv_enable)
        else $error("converting in standby");
    reset_off_a: assert property (filter_reset && $past(filter_reset) |-> !conv_enable)
        else $error("converting in reset");
    reset_len_a: assert property ($fell(filter_reset) |-> frst_cnt_r == 6'h24)
        else $error("reset window length wrong");
    idle_out_a: assert property (cs_n[*2] |-> !dout_oe)
        else $error("output driven while deselected");
    cover property ($fell(data_ready_n));
    cover property ($rose(standby));
    cover property ($fell(filter_reset));
endmodule
bind adcsd_decoder adcsd_decoder_sva u_sva (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
    .dout_oe(dout_oe), .conv_valid(conv_valid), .data_ready_n(data_ready_n),
    .conv_enable(conv_enable), .standby(standby), .filter_reset(filter_reset),
    .offset_calibrate_cmd(offset_calibrate_cmd));
`default_nettype wire

// >>> adc_spi_command_decoder_tb.sv
// self-checking bench of the serial command decoder
// assumes the host model drives the link; sys_clk inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
module adc_spi_command_decoder_tb;
    import adcsd_pkg::*;
    logic sys_clk, rst, sclk, cs_n, din, dout, dout_oe, start_pin, conv_valid;
    logic data_ready_n, conv_enable, standby, filter_reset, offset_calibrate_cmd;
    logic calibration_enable_bit, read_continuous;
    logic [DATA_W-1:0] conv_data, d, res;
    logic [7:0] rx, v, w;
    int err_total = 0;
    int n_compared = 0;
    int n_cal = 0;
    int cyc = 0;
    adcsd_decoder u_dut (.sys_clk, .rst, .sclk, .cs_n, .din, .dout, .dout_oe, .start_pin,
        .conv_valid, .conv_data, .data_ready_n, .conv_enable, .standby, .filter_reset,
        .offset_calibrate_cmd, .calibration_enable_bit, .read_continuous);
    adcsd_host u_host (.sclk, .cs_n, .din, .dout);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        cyc++;
        if (offset_calibrate_cmd === 1'b1) n_cal++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host.open_f();
        u_host.xfer(b, rx);
        u_host.close_f();
        repeat (4) @(negedge sys_clk);
    endtask
    // byte k of a result as it streams out msb first
    function automatic logic [7:0] res_byte(input logic [71:0] r, input int k);
        return r[71 - 8 * k -: 8];
    endfunction
    // two-register access, count byte 01
    task automatic reg2(input logic [2:0] pfx, input logic [4:0] a, input logic [15:0] x);
        u_host.open_f();
        u_host.xfer({pfx, a}, rx);
        u_host.xfer(8'h01, rx);
        // read data bytes go out as zeros so a skipped read decodes nothing
        u_host.xfer((pfx == PFX_REGISTER_READ_CMD) ? 8'h00 : x[15:8], rx);
        if (pfx == PFX_REGISTER_READ_CMD) chk(72'(rx), 72'(x[15:8]));
        u_host.xfer((pfx == PFX_REGISTER_READ_CMD) ? 8'h00 : x[7:0], rx);
        if (pfx == PFX_REGISTER_READ_CMD) chk(72'(rx), 72'(x[7:0]));
        u_host.close_f();
    endtask
    task automatic conv(input logic [71:0] x);
        repeat (3) @(negedge sys_clk);
        conv_valid = 1'b1;
        conv_data = x;
        @(negedge sys_clk);
        conv_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic rdres(input logic op, input logic [71:0] e);
        u_host.open_f();
        if (op) u_host.xfer(OP_RDATA, rx);
        for (int i = 0; i < 9; i++) begin
            u_host.xfer(8'h00, rx);
            res = {res[63:0], rx};
        end
        u_host.close_f();
        chk(res, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        start_pin = 1'b0;
        conv_valid = 1'b0;
        conv_data = '0;
        void'($urandom(32'h029b));
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(72'({data_ready_n, conv_enable, standby, read_continuous}), 72'(4'b1001));
        cmd(OP_STOP_CONTINUOUS_CMD);
        chk(72'(read_continuous), 72'(0));
        v = 8'($urandom);
        w = {1'b1, 7'($urandom)};
        reg2(PFX_REGISTER_WRITE_CMD, REG_RESP2 - 5'h01, {v, w});
        chk(72'(calibration_enable_bit), 72'(1));
        reg2(PFX_REGISTER_READ_CMD, REG_RESP2 - 5'h01, {v, w});
        reg2(PFX_REGISTER_WRITE_CMD, REG_ID, {w, v});
        reg2(PFX_REGISTER_READ_CMD, REG_ID, {ID_VALUE, v});
        cmd(OP_OFFCAL);
        cmd(8'hFF);
        chk(72'({n_cal, conv_enable, read_continuous}), 72'({32'd1, 2'b00}));
        cmd(OP_START);
        cmd(OP_START);
        chk(72'(conv_enable), 72'(1));
        d = {$urandom, $urandom, 8'($urandom)};
        conv(d);
        rdres(1'b1, d);
        cmd(OP_STOP);
        chk(72'(conv_enable), 72'(1));
        d = {$urandom, $urandom, 8'($urandom)};
        conv(d);
        chk(72'(conv_enable), 72'(0));
        rdres(1'b1, d);
        conv(~d);
        cmd(OP_STOP);
        chk(72'({data_ready_n, conv_enable}), 72'(2'b10));
        cmd(OP_START);
        cmd(OP_READ_CONTINUOUS_CMD);
        d = {$urandom, $urandom, 8'($urandom)};
        conv(d);
        rdres(1'b0, d);
        reg2(PFX_REGISTER_READ_CMD, REG_RESP2, {res_byte(d, 2), res_byte(d, 3)});
        chk(72'(read_continuous), 72'(1));
        cmd(OP_STOP_CONTINUOUS_CMD);
        cmd(OP_STANDBY);
        chk(72'({standby, conv_enable}), 72'(2'b10));
        cmd(OP_WAKE);
        chk(72'({standby, conv_enable}), 72'(2'b01));
        cmd(OP_RESET);
        chk(72'(filter_reset), 72'(1));
        repeat (40) @(negedge sys_clk);
        chk(72'({filter_reset, calibration_enable_bit}), 72'(0));
        report_and_stop();
    end
endmodule
`default_nettype wire
